/* rtl/btsb_map.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * bit-test-and-set / branch-to-subroutine execution block.
 * Assumes a 32-bit classic Wishbone slave port with byte addresses.
 */
`ifndef BTSB_MAP_SVH
`define BTSB_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BTSB_OFS_CTRL     8'h00
`define BTSB_OFS_OPCODE   8'h04
`define BTSB_OFS_EXT      8'h08
`define BTSB_OFS_PC       8'h0C
`define BTSB_OFS_STATUS   8'h10
`define BTSB_OFS_SP       8'h14
`define BTSB_OFS_STK_HI   8'h18
`define BTSB_OFS_STK_LO   8'h1C
`define BTSB_OFS_DREG     8'h20
`define BTSB_OFS_CYCLES   8'h24
`define BTSB_OFS_AREG0    8'h28
`define BTSB_OFS_AREG7    8'h44

// ----------------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------------
`define BTSB_CTRL_START   0
`define BTSB_CTRL_BUSY    0
`define BTSB_CTRL_ILLEGAL 1
`define BTSB_CTRL_DONE    2

// ----------------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------------
`define BTSB_BIT_LSB      0
`define BTSB_BIT_W        5
`define BTSB_SPACE_POS    8
`define BTSB_SHORT_LSB    12
`define BTSB_SHORT_W      7
`define BTSB_DREG_LSB     13
`define BTSB_DREG_W       7
`define BTSB_EA_REG_LSB   14
`define BTSB_EA_MODE_LSB  17
`define BTSB_SEL_SR       7'h79
`define BTSB_SEL_AREG     4'h5
`define BTSB_IO_BASE      32'hFFFFFF80
`define BTSB_CARRY_POS    0

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define BTSB_RST_WORD     32'h00000000
`define BTSB_BIT_TEST_AND_SET_OP_BASE    8'h04
`define BTSB_BSR_BASE     8'h06
`define BTSB_STACK_DEPTH  16

`endif

/* rtl/btsb_pkg.sv */
/*
 * Types of the bit-test-and-set / branch-to-subroutine execution block.
 * Assumes btsb_map.svh supplies the numeric constants.
 */
package btsb_pkg;

	// ------------------------------------------------------------------
	// Instruction kinds and sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		BTSB_K_NONE      = 3'h0,
		BTSB_K_BIT_TEST_AND_SET_OP_REG  = 3'h1,
		BTSB_K_BIT_TEST_AND_SET_OP_IO   = 3'h2,
		BTSB_K_BIT_TEST_AND_SET_OP_ABS  = 3'h3,
		BTSB_K_BIT_TEST_AND_SET_OP_EA   = 3'h4,
		BTSB_K_BSR_SHORT = 3'h5,
		BTSB_K_BSR_LONG  = 3'h6,
		BTSB_K_BSR_REG   = 3'h7
	} btsb_kind_t;

	typedef enum logic [2:0] {
		BTSB_S_IDLE   = 3'h0,
		BTSB_S_EXEC   = 3'h1,
		BTSB_S_READ   = 3'h3,
		BTSB_S_WRITE  = 3'h2,
		BTSB_S_FINISH = 3'h6
	} btsb_state_t;

	// ------------------------------------------------------------------
	// Operand memory request
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        req;
		logic        lock;
		logic        we;
		logic        space;
		logic [31:0] addr;
		logic [31:0] wdata;
	} btsb_mem_t;

endpackage

/* rtl/btsb_core.sv */
/*
 * Execution block for the bit test and set instruction and the branch to
 * subroutine instruction, with a classic Wishbone register slave and an
 * operand memory master port.
 * Assumes one 125 MHz clock, synchronous active-high reset, and an operand
 * memory that answers a request with mem_ack_i and honours mem_o.lock.
 */
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "btsb_map.svh"

module btsb_core #(
	parameter logic [7:0] JUMP_EXTRA  = 8'h00,
	parameter int         STACK_DEPTH = `BTSB_STACK_DEPTH
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	output btsb_pkg::btsb_mem_t    mem_o,
	input  wire logic [31:0]       mem_rdata_i,
	input  wire logic              mem_ack_i,
	output logic                   busy_o
);

	localparam int SPW = $clog2(STACK_DEPTH);

	// ------------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------------
	function automatic btsb_pkg::btsb_kind_t decode(input logic [31:0] op);
		btsb_pkg::btsb_kind_t k;
		k = btsb_pkg::BTSB_K_NONE;
		if (op[31:20] == 12'h023 && op[12:5] == 8'h60)
			k = btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_REG;
		else if (op[31:20] == 12'h022 && op[11:9] == 3'h6 && op[7:5] == 3'h0)
			k = op[19] ? btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_IO : btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_ABS;
		else if (op[31:20] == 12'h020 && op[13:9] == 5'h06 && op[7:5] == 3'h0)
			k = btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_EA;
		else if (op[31:22] == 10'h00F && op[13:7] == 7'h7E)
			k = btsb_pkg::BTSB_K_BSR_SHORT;
		else if (op[31:17] == 15'h01A1 && op[13:0] == 14'h3F00)
			k = btsb_pkg::BTSB_K_BSR_LONG;
		else if (op[31:14] == 18'h00D00 && op[13:3] == 11'h7E0)
			k = btsb_pkg::BTSB_K_BSR_REG;
		return k;
	endfunction

	function automatic logic [31:0] bit_mask(input logic [4:0] n);
		return 32'h00000001 << n;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	btsb_pkg::btsb_state_t state;
	btsb_pkg::btsb_kind_t  kind;
	logic [31:0]           opcode;
	logic [31:0]           ext;
	logic [31:0]           pc;
	logic [31:0]           status;
	logic [SPW-1:0]        sp;
	logic [31:0]           stk_hi [STACK_DEPTH];
	logic [31:0]           stk_lo [STACK_DEPTH];
	logic [31:0]           dreg;
	logic [31:0]           areg [8];
	logic [7:0]            base_cnt;
	logic [7:0]            total_cnt;
	logic [7:0]            last_cycles;
	logic                  illegal;
	logic                  done;
	btsb_pkg::btsb_mem_t   mem_reg;

	logic                  bus_wr;
	logic                  bus_rd_ok;
	logic                  start;
	logic                  waiting;
	logic                  finish_ok;
	logic [4:0]            bit_n;
	logic [2:0]            ea_reg;
	logic [2:0]            ea_mode;
	logic [6:0]            dsel;
	logic [31:0]           ea_addr;
	logic [31:0]           next_areg;
	logic                  ea_ok;
	logic [31:0]           disp;
	logic [31:0]           reg_old;
	logic [7:0]            need;

	assign bus_wr    = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (wb_sel_i == 4'hF);
	assign start     = bus_wr & (wb_adr_i == `BTSB_OFS_CTRL) & wb_dat_i[`BTSB_CTRL_START]
		& (state == btsb_pkg::BTSB_S_IDLE);
	assign bus_rd_ok = (state == btsb_pkg::BTSB_S_IDLE);
	assign kind      = decode(opcode);
	assign bit_n     = opcode[`BTSB_BIT_LSB +: `BTSB_BIT_W];
	assign ea_reg    = opcode[`BTSB_EA_REG_LSB +: 3];
	assign ea_mode   = opcode[`BTSB_EA_MODE_LSB +: 3];
	assign dsel      = opcode[`BTSB_DREG_LSB +: `BTSB_DREG_W];
	assign waiting   = (state == btsb_pkg::BTSB_S_READ || state == btsb_pkg::BTSB_S_WRITE)
		& ~mem_ack_i;
	assign busy_o    = (state != btsb_pkg::BTSB_S_IDLE);

	// ------------------------------------------------------------------
	// Effective address and displacement
	// ------------------------------------------------------------------
	always_comb
	begin
		ea_addr   = areg[ea_reg];
		next_areg = areg[ea_reg];
		ea_ok     = 1'b1;
		unique case (ea_mode)
			3'h0: next_areg = areg[ea_reg] - 32'h00000001;
			3'h1: next_areg = areg[ea_reg] + 32'h00000001;
			3'h4: next_areg = areg[ea_reg];
			3'h6: ea_addr = ext;
			3'h7:
			begin
				ea_addr   = areg[ea_reg] - 32'h00000001;
				next_areg = ea_addr;
			end
			default: ea_ok = 1'b0;
		endcase
	end

	always_comb
	begin
		unique case (kind)
			btsb_pkg::BTSB_K_BSR_SHORT:
				disp = {{17{opcode[21]}}, opcode[21:14], opcode[6:0]};
			btsb_pkg::BTSB_K_BSR_LONG:
				disp = ext;
			btsb_pkg::BTSB_K_BSR_REG:
				disp = areg[opcode[2:0]];
			default:
				disp = 32'h00000000;
		endcase
	end

	always_comb
	begin
		if (dsel[6:3] == `BTSB_SEL_AREG)
			reg_old = areg[dsel[2:0]];
		else
			reg_old = dreg;
	end

	assign need = kind[2] & (kind != btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_EA)
		? `BTSB_BSR_BASE + JUMP_EXTRA
		: `BTSB_BIT_TEST_AND_SET_OP_BASE;
	assign finish_ok = (base_cnt >= need - 8'h01);

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= btsb_pkg::BTSB_S_IDLE;
		else
		begin
			unique case (state)
				btsb_pkg::BTSB_S_IDLE:
					if (start)
						state <= btsb_pkg::BTSB_S_EXEC;
				btsb_pkg::BTSB_S_EXEC:
					if ((kind == btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_EA && ea_ok)
						|| kind == btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_IO
						|| kind == btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_ABS)
						state <= btsb_pkg::BTSB_S_READ;
					else
						state <= btsb_pkg::BTSB_S_FINISH;
				btsb_pkg::BTSB_S_READ:
					if (mem_ack_i)
						state <= btsb_pkg::BTSB_S_WRITE;
				btsb_pkg::BTSB_S_WRITE:
					if (mem_ack_i)
						state <= btsb_pkg::BTSB_S_FINISH;
				btsb_pkg::BTSB_S_FINISH:
					if (finish_ok)
						state <= btsb_pkg::BTSB_S_IDLE;
				default:
					state <= btsb_pkg::BTSB_S_IDLE;
			endcase
		end
	end

	// Wait cycles of the operand memory are not counted toward the base,
	// so the total is the base figure plus whatever the memory stalls.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			base_cnt    <= 8'h00;
			total_cnt   <= 8'h00;
			last_cycles <= 8'h00;
			done        <= 1'b0;
		end
		else if (start)
		begin
			base_cnt  <= 8'h00;
			total_cnt <= 8'h00;
			done      <= 1'b0;
		end
		else if (busy_o)
		begin
			if (!waiting)
				base_cnt <= base_cnt + 8'h01;
			total_cnt <= total_cnt + 8'h01;
			if (state == btsb_pkg::BTSB_S_FINISH && finish_ok)
			begin
				last_cycles <= total_cnt + 8'h01;
				done        <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Operand memory master
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mem_reg.req   <= 1'b0;
			mem_reg.lock  <= 1'b0;
			mem_reg.addr  <= `BTSB_RST_WORD;
			mem_reg.space <= 1'b0;
			mem_reg.we    <= 1'b0;
			mem_reg.wdata <= `BTSB_RST_WORD;
		end
		else if (state == btsb_pkg::BTSB_S_EXEC)
		begin
			mem_reg.space <= opcode[`BTSB_SPACE_POS];
			mem_reg.we    <= 1'b0;
			unique case (kind)
				btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_IO:
					mem_reg.addr <= `BTSB_IO_BASE
						| {25'h0, opcode[`BTSB_SHORT_LSB +: `BTSB_SHORT_W]};
				btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_ABS:
					mem_reg.addr <= {25'h0, opcode[`BTSB_SHORT_LSB +: `BTSB_SHORT_W]};
				default:
					mem_reg.addr <= ea_addr;
			endcase
		end
		else if (state == btsb_pkg::BTSB_S_READ && mem_ack_i)
		begin
			mem_reg.we    <= 1'b1;
			mem_reg.wdata <= mem_rdata_i | bit_mask(bit_n);
		end
		else if (state == btsb_pkg::BTSB_S_WRITE && mem_ack_i)
			mem_reg.we <= 1'b0;
	end

	// The lock spans both accesses so no other master slips in between.
	always_comb
	begin
		mem_o      = mem_reg;
		mem_o.req  = (state == btsb_pkg::BTSB_S_READ) | (state == btsb_pkg::BTSB_S_WRITE);
		mem_o.lock = (state == btsb_pkg::BTSB_S_READ) | (state == btsb_pkg::BTSB_S_WRITE);
	end

	// ------------------------------------------------------------------
	// Status register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status <= `BTSB_RST_WORD;
		else if (state == btsb_pkg::BTSB_S_EXEC && kind == btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_REG)
		begin
			if (dsel == `BTSB_SEL_SR)
				status <= status | bit_mask(bit_n);
			else
				status[`BTSB_CARRY_POS] <= reg_old[bit_n];
		end
		else if (state == btsb_pkg::BTSB_S_READ && mem_ack_i)
			status[`BTSB_CARRY_POS] <= mem_rdata_i[bit_n];
		else if (bus_wr && bus_rd_ok && wb_adr_i == `BTSB_OFS_STATUS)
			status <= wb_dat_i;
	end

	// ------------------------------------------------------------------
	// Register-direct operands and address registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dreg <= `BTSB_RST_WORD;
		else if (state == btsb_pkg::BTSB_S_EXEC && kind == btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_REG
			&& dsel != `BTSB_SEL_SR && dsel[6:3] != `BTSB_SEL_AREG)
			dreg <= dreg | bit_mask(bit_n);
		else if (bus_wr && bus_rd_ok && wb_adr_i == `BTSB_OFS_DREG)
			dreg <= wb_dat_i;
	end

	for (genvar i = 0; i < 8; i++)
	begin : g_areg
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				areg[i] <= `BTSB_RST_WORD;
			else if (state == btsb_pkg::BTSB_S_EXEC && kind == btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_REG
				&& dsel[6:3] == `BTSB_SEL_AREG && dsel[2:0] == 3'(i))
				areg[i] <= areg[i] | bit_mask(bit_n);
			else if (state == btsb_pkg::BTSB_S_EXEC && kind == btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_EA
				&& ea_ok && ea_reg == 3'(i))
				areg[i] <= next_areg;
			else if (bus_wr && bus_rd_ok && wb_adr_i == `BTSB_OFS_AREG0 + 8'(4 * i))
				areg[i] <= wb_dat_i;
		end
	end

	// ------------------------------------------------------------------
	// Program counter, stack and instruction registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pc <= `BTSB_RST_WORD;
			sp <= '0;
		end
		else if (state == btsb_pkg::BTSB_S_EXEC && kind[2] && kind != btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_EA)
		begin
			sp                   <= sp + 1'b1;
			stk_hi[SPW'(sp + 1'b1)] <= pc;
			stk_lo[SPW'(sp + 1'b1)] <= status;
			pc                   <= pc + disp;
		end
		else if (bus_wr && bus_rd_ok && wb_adr_i == `BTSB_OFS_PC)
			pc <= wb_dat_i;
		else if (bus_wr && bus_rd_ok && wb_adr_i == `BTSB_OFS_SP)
			sp <= wb_dat_i[SPW-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			opcode  <= `BTSB_RST_WORD;
			ext     <= `BTSB_RST_WORD;
			illegal <= 1'b0;
		end
		else
		begin
			if (bus_wr && bus_rd_ok && wb_adr_i == `BTSB_OFS_OPCODE)
				opcode <= wb_dat_i;
			if (bus_wr && bus_rd_ok && wb_adr_i == `BTSB_OFS_EXT)
				ext <= wb_dat_i;
			if (start)
				illegal <= 1'b0;
			else if (state == btsb_pkg::BTSB_S_EXEC)
				illegal <= (kind == btsb_pkg::BTSB_K_NONE)
					| (kind == btsb_pkg::BTSB_K_BIT_TEST_AND_SET_OP_EA & ~ea_ok);
		end
	end

	// ------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `BTSB_RST_WORD;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			wb_dat_o <= `BTSB_RST_WORD;
			if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
			begin
				unique case (wb_adr_i)
					`BTSB_OFS_CTRL:   wb_dat_o <= {29'h0, done, illegal, busy_o};
					`BTSB_OFS_OPCODE: wb_dat_o <= opcode;
					`BTSB_OFS_EXT:    wb_dat_o <= ext;
					`BTSB_OFS_PC:     wb_dat_o <= pc;
					`BTSB_OFS_STATUS: wb_dat_o <= status;
					`BTSB_OFS_SP:     wb_dat_o <= 32'(sp);
					`BTSB_OFS_STK_HI: wb_dat_o <= stk_hi[sp];
					`BTSB_OFS_STK_LO: wb_dat_o <= stk_lo[sp];
					`BTSB_OFS_DREG:   wb_dat_o <= dreg;
					`BTSB_OFS_CYCLES: wb_dat_o <= {24'h0, last_cycles};
					default:
						if (wb_adr_i >= `BTSB_OFS_AREG0 && wb_adr_i <= `BTSB_OFS_AREG7
							&& wb_adr_i[1:0] == 2'h0)
							wb_dat_o <= areg[3'((wb_adr_i - `BTSB_OFS_AREG0) >> 2)];
				endcase
			end
		end
	end

endmodule // btsb_core

/* dv/btsb_core_properties.sv */
/*
 * Port checker of btsb_core: bus answer and operand access order.
 * Assumes it is bound to btsb_core and sees only its ports.
 */
`timescale 1ns/1ps
module btsb_core_properties #(
	parameter logic [7:0]	JUMP_EXTRA = 8'h00,
	parameter int		STACK_DEPTH = 16
) (
	input wire logic		clk_i,
	input wire logic		rst_i,
	input wire logic		wb_cyc_i,
	input wire logic		wb_stb_i,
	input wire logic		wb_ack_o,
	input wire btsb_pkg::btsb_mem_t	mem_o,
	input wire logic [31:0]		mem_rdata_i,
	input wire logic		mem_ack_i,
	input wire logic		busy_o
);
	wire	rd_end = mem_o.req && !mem_o.we && mem_ack_i;
	wire	wr_end = mem_o.req && mem_o.we && mem_ack_i;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------------
	// Operand read-modify-write
	// ------------------------------------------------------------------
	a_req_locked: assert property (mem_o.req |-> mem_o.lock && busy_o)
		else $error("operand request without lock");
	a_read_first: assert property ($rose(mem_o.req) |-> !mem_o.we)
		else $error("operand access does not start with a read");
	a_read_holds: assert property (mem_o.req && !mem_o.we && !mem_ack_i |=> mem_o.req && !mem_o.we)
		else $error("operand read dropped before its answer");
	a_read_then_write: assert property (rd_end |=> mem_o.req && mem_o.we && mem_o.lock)
		else $error("locked write does not follow the read");
	a_same_operand: assert property (rd_end |=> mem_o.addr == $past(mem_o.addr) && mem_o.space == $past(mem_o.space))
		else $error("write goes to another operand");
	a_write_sets_bit: assert property (rd_end |=> (mem_o.wdata & $past(mem_rdata_i)) == $past(mem_rdata_i) && $countones(mem_o.wdata ^ $past(mem_rdata_i)) <= 1)
		else $error("written word is not the read word with one bit set");
	a_write_holds: assert property (mem_o.req && mem_o.we && !mem_ack_i |=> mem_o.req && mem_o.we && $stable(mem_o.wdata))
		else $error("operand write changed before its answer");
	a_finish_one: assert property (wr_end |=> busy_o ##1 !busy_o)
		else $error("finish after write is not one cycle");
	a_min_length: assert property ($rose(busy_o) |-> busy_o [*4])
		else $error("instruction shorter than four cycles");

	// ------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus answer longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("bus answer without request");
endmodule // btsb_core_properties

/* dv/tb.sv */
/*
 * Self-checking bench of btsb_core: bus master, operand memory and checks.
 * Assumes the design files and the checker file are compiled first.
 */
`timescale 1ns/1ps
`include "btsb_map.svh"
module tb;
	localparam logic [7:0]	JX = 8'h02;
	localparam logic [14:0]	MODES = {3'h7, 3'h6, 3'h4, 3'h1, 3'h0};
	logic			clk_i = 1'b0;
	logic			rst_i = 1'b1;
	logic			cyc = 1'b0;
	logic			stb = 1'b0;
	logic			we = 1'b0;
	logic [7:0]		adr = 8'h00;
	logic [3:0]		sel = 4'h0;
	logic [31:0]		wdat = 32'h0;
	logic [31:0]		rdat;
	logic			ack;
	btsb_pkg::btsb_mem_t	mem;
	logic [31:0]		mrd = 32'h0;
	logic			mack = 1'b0;
	logic			busy;
	logic [31:0]		mem_word = 32'h0;
	logic [3:0]		sp_m = 4'h0;
	int			seed = 32'h8FD56CA8;
	int			bad_count = 0;
	int			tests_run = 0;
	int			waits = 0;
	logic [63:0]		rd_q[$];
	logic [64:0]		mw_q[$];

	initial
		forever
			#4 clk_i = ~clk_i;

	btsb_core #(.JUMP_EXTRA(JX)) i_btsb_core (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mem_o(mem),
		.mem_rdata_i(mrd), .mem_ack_i(mack), .busy_o(busy));

	task automatic mism(input string s);
		bad_count++;
		$display("mismatch at %0t: %s", $time, s);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [31:0] e, input logic [31:0] m);
		int n;
		n = 0;
		rd_q.push_back({m, e});
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		if (ack !== 1'b1)
		begin
			mism("bus answer missing");
			report_and_stop();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF, 32'h0, 32'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hF, e, 32'hFFFFFFFF);
	endtask

	task automatic run(input logic [31:0] op, input logic [31:0] ext, input logic [31:0] base,
		input logic [31:0] c);
		int n;
		n = 0;
		wr(`BTSB_OFS_OPCODE, op);
		wr(`BTSB_OFS_EXT, ext);
		waits = 0;
		wr(`BTSB_OFS_CTRL, 32'h1);
		while (busy !== 1'b0 && n < 200)
		begin
			@(posedge clk_i);
			n++;
		end
		if (busy !== 1'b0)
		begin
			mism("instruction hangs");
			report_and_stop();
		end
		wb(1'b0, `BTSB_OFS_CTRL, 32'h0, 4'hF, c, 32'h7);
		rd(`BTSB_OFS_CYCLES, base + waits);
	endtask

	// ------------------------------------------------------------------
	// Result watchers and operand memory
	// ------------------------------------------------------------------
	always @(posedge clk_i)
	begin
		logic [63:0] x;
		if (ack === 1'b1 && rd_q.size() > 0)
		begin
			x = rd_q.pop_front();
			if (x[63:32] != 32'h0)
			begin
				tests_run++;
				if ((rdat & x[63:32]) !== (x[31:0] & x[63:32]))
					mism($sformatf("read %h want %h", rdat, x[31:0]));
			end
		end
	end

	// The memory answers after a random delay, so every access sees waits.
	always @(posedge clk_i)
	begin
		logic [64:0] y;
		if (mem.req === 1'b1 && mack !== 1'b1)
			waits++;
		if (mem.req === 1'b1 && mem.we === 1'b1 && mack === 1'b1)
		begin
			y = mw_q.size() > 0 ? mw_q.pop_front() : '1;
			tests_run++;
			if ({mem.space, mem.addr, mem.wdata} !== y)
				mism("operand write differs");
		end
		if (mem.req === 1'b1 && mack !== 1'b1 && ($random(seed) & 1) == 0)
		begin
			mack <= 1'b1;
			mrd <= mem_word;
		end
		else
		begin
			mack <= 1'b0;
			mrd <= $random(seed);
		end
	end

	initial
	begin
		logic [31:0]	v;
		logic [31:0]	s;
		logic [31:0]	r;
		logic [31:0]	e;
		logic [31:0]	ad;
		logic [31:0]	rn;
		logic [31:0]	op;
		logic [7:0]	a;
		logic [6:0]	f;
		logic [4:0]	b;
		logic [2:0]	md;
		repeat (3)
			@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(`BTSB_OFS_STATUS, 32'h0);
		wb(1'b1, `BTSB_OFS_DREG, 32'hFFFFFFFF, 4'h3, 32'h0, 32'h0);
		rd(`BTSB_OFS_DREG, 32'h0);
		rd(8'h48, 32'h0);
		$display("test bus done");
		for (int i = 0; i < 8; i++)
		begin
			b = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($random(seed));
			v = $random(seed);
			s = $random(seed);
			a = i[0] ? 8'(`BTSB_OFS_AREG0 + 4 * i) : `BTSB_OFS_DREG;
			wr(a, v);
			wr(`BTSB_OFS_STATUS, s);
			run({12'h023, i[0] ? 7'(32'h28 + i) : 7'h00, 1'b0, 4'hC, 3'h0, b}, 32'h0, 32'h4, 32'h4);
			rd(a, v | (32'h1 << b));
			rd(`BTSB_OFS_STATUS, {s[31:1], v[b]});
		end
		$display("test register target done");
		for (int i = 0; i < 21; i++)
		begin
			s = $random(seed) & ~(32'h1 << i);
			wr(`BTSB_OFS_STATUS, s);
			run({12'h023, 7'h79, 1'b0, 4'hC, 3'h0, 5'(i)}, 32'h0, 32'h4, 32'h4);
			rd(`BTSB_OFS_STATUS, s | (32'h1 << i));
		end
		$display("test status target done");
		for (int k = 0; k < 9; k++)
		begin
			b = 5'($random(seed));
			f = k[0] ? 7'h7F : 7'($random(seed));
			r = $random(seed);
			e = $random(seed);
			s = $random(seed);
			mem_word = $random(seed);
			md = (k < 4) ? 3'h4 : MODES[3 * ((k + 1) % 5) +: 3];
			ad = (md == 3'h6) ? e : (md == 3'h7) ? r - 1 : r;
			ad = (k < 2) ? {25'h0, f} : (k < 4) ? (32'hFFFFFF80 | f) : ad;
			rn = (md == 3'h1) ? r + 1 : (md == 3'h0 || md == 3'h7) ? r - 1 : r;
			op = {12'h020, md, 3'h3, 5'h06, s[0], 3'h0, b};
			op = (k < 4) ? {12'h022, 1'(k >= 2), f, 3'h6, s[0], 3'h0, b} : op;
			wr(`BTSB_OFS_AREG0 + 8'h0C, r);
			wr(`BTSB_OFS_STATUS, s);
			mw_q.push_back({s[0], ad, mem_word | (32'h1 << b)});
			run(op, e, 32'h4, 32'h4);
			rd(`BTSB_OFS_STATUS, {s[31:1], mem_word[b]});
			rd(`BTSB_OFS_AREG0 + 8'h0C, rn);
		end
		$display("test memory target done");
		for (int k = 0; k < 2; k++)
		begin
			s = $random(seed);
			wr(`BTSB_OFS_STATUS, s);
			op = k ? 32'hFFFFFFFF : {12'h020, 3'h2, 3'h3, 5'h06, 1'b0, 3'h0, 5'h00};
			run(op, 32'h0, 32'h4, 32'h6);
			rd(`BTSB_OFS_STATUS, s);
		end
		$display("test illegal code done");
		for (int j = 0; j < 6; j++)
		begin
			r = $random(seed);
			s = $random(seed);
			e = $random(seed);
			op = 32'h03423F00;
			if (j % 3 == 0)
			begin
				e[14] = (j == 0);
				e = {{17{e[14]}}, e[14:0]};
				op = {10'h00F, e[14:7], 6'h3F, 1'b0, e[6:0]};
			end
			else if (j % 3 == 2)
			begin
				wr(`BTSB_OFS_AREG0 + 8'h14, e);
				op = 32'h03403F05;
			end
			wr(`BTSB_OFS_PC, r);
			wr(`BTSB_OFS_STATUS, s);
			run(op, (j % 3 == 1) ? e : ~e, 32'h6 + JX, 32'h4);
			sp_m = sp_m + 4'h1;
			rd(`BTSB_OFS_SP, {28'h0, sp_m});
			rd(`BTSB_OFS_STK_HI, r);
			rd(`BTSB_OFS_STK_LO, s);
			rd(`BTSB_OFS_PC, r + e);
			rd(`BTSB_OFS_STATUS, s);
		end
		$display("test subroutine branch done");
		report_and_stop();
	end
endmodule // tb

bind btsb_core btsb_core_properties #(.JUMP_EXTRA(JUMP_EXTRA), .STACK_DEPTH(STACK_DEPTH))
	i_btsb_core_properties (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
	.mem_ack_i(mem_ack_i), .busy_o(busy_o));
